// ---- design/alarm_compare.sv ----
`timescale 1ns/1ps
`default_nettype none

module alarm_compare (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [4:0] alarm_month,
   input  wire logic [7:0] alarm_year,
   input  wire logic [4:0] current_month,
   input  wire logic [7:0] current_year,
   input  wire logic       time_match,
   input  wire logic       twelve_hour,
   input  wire logic       alarm_pm,
   input  wire logic       current_pm,
   output logic            alarm_event
);

   typedef struct packed {
      logic matched;
      logic event_out;
   } cmp_t;

   cmp_t state;
   cmp_t next_state;
   logic full_match;

   // ------------------------------------------------------------
   // Month, year and, in twelve-hour mode only, meridiem join the outer time match
   // ------------------------------------------------------------
   always_comb begin
      full_match = time_match && (alarm_month == current_month) && // [R4]
                   (alarm_year == current_year) &&
                   (!twelve_hour || alarm_pm == current_pm);        // [R15]
      next_state.matched   = full_match;
      // One event per match, not one per cycle while it lasts
      next_state.event_out = full_match && !state.matched;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign alarm_event = state.event_out;

   event_cause_a: assert property (@(posedge clock) disable iff (rst) // [R4]
      alarm_event |-> $past(alarm_month == current_month &&
                            alarm_year == current_year && time_match))
      else $error("alarm event without date match");

endmodule // alarm_compare

`default_nettype wire

// ---- design/rtc_ctrl_regs.sv ----
// Notes on behaviour
// R1 - Writes to alarm month, year and control ignored until keys written
// R2 - Alarm month is BCD: tens in bit 4, units in bits 3-0
// R3 - Alarm year is BCD: tens in bits 7-4, units in bits 3-0
// R4 - Stored alarm month and year take part in the alarm comparison
// R5 - Control bit 7 sets isolation, write-only, always reads zero
// R6 - Software must set isolation bit explicitly on read-modify-write
// R7 - Control bit 6 disables the module and gates the reference clock
// R8 - Software sets disable only when the clock is never needed
// R9 - While bit 5 is one, counter is preloaded and timekeeping halts (no preload while bit 6 disable is set)
// R10 - Software pulses the preload bit zero, one, zero
// R11 - Control bit 3 selects twelve-hour mode, zero selects 24-hour
// R12 - Control bit 2 enables compensation once every hour
// R13 - Control bit 1 rounds to nearest minute once, on next time read
// R14 - Control bit 0 runs or stops the reference counter
// R15 - Alarm hour bit 7 marks PM in twelve-hour mode
// R16 - Enabled alarm interrupt raised when alarm date and time match
// R17 - Reserved bits read zero and ignore writes
// R18 - Protected registers still read their contents while locked
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module rtc_ctrl_regs (
   input  wire logic        CLOCK,
   input  wire logic        RST,
   input  wire logic [5:0]  ADDRESS,
   input  wire logic        READ,
   input  wire logic        WRITE,
   input  wire logic [31:0] WRITEDATA,
   input  wire logic [3:0]  BYTEENABLE,
   output logic [31:0]      READDATA,
   output logic             WAITREQUEST,
   input  wire logic [4:0]  CURRENT_MONTH,
   input  wire logic [7:0]  CURRENT_YEAR,
   input  wire logic        TIME_MATCH,
   input  wire logic        ALARM_HOUR_PM,
   input  wire logic        CURRENT_HOUR_PM,
   input  wire logic        TIME_READ,
   input  wire logic        HOUR_TICK,
   output logic             COUNTER_RUN,
   output logic             COUNTER_PRELOAD,
   output logic             REF_CLOCK_ENABLE,
   output logic             ISOLATION_ENABLE,
   output logic             TWELVE_HOUR_SELECT,
   output logic             ROUND_NOW,
   output logic             COMPENSATE_NOW,
   output logic             IRQ
);

   typedef struct packed {
      logic [4:0]  month;
      logic [7:0]  year;
      logic [7:0]  ctrl;
      logic [3:0]  status;
      logic [3:0]  mask;
      logic        ack;
      logic [31:0] rdata;
      logic        round_now;
      logic        comp_now;
   } regs_t;

   regs_t state;
   regs_t next_state;
   logic  unlocked;
   logic  alarm_event;
   logic  request;
   logic  wr_now;
   logic  low_lane;
   logic  protected_hit;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   write_lock write_lock_inst (
      .clock            (CLOCK),
      .rst              (RST),
      .key_first_write  (wr_now && ADDRESS == rtc_ctrl_pkg::OFS_KEY_FIRST),
      .key_second_write (wr_now && ADDRESS == rtc_ctrl_pkg::OFS_KEY_SECOND),
      .write_data       (WRITEDATA),
      .unlocked         (unlocked)
   );

   alarm_compare alarm_compare_inst (
      .clock         (CLOCK),
      .rst           (RST),
      .alarm_month   (state.month),
      .alarm_year    (state.year),
      .current_month (CURRENT_MONTH),
      .current_year  (CURRENT_YEAR),
      .time_match    (TIME_MATCH),
      .twelve_hour   (state.ctrl[rtc_ctrl_pkg::CTL_TWELVE]),
      .alarm_pm      (ALARM_HOUR_PM),
      .current_pm    (CURRENT_HOUR_PM),
      .alarm_event   (alarm_event)
   );

   // ------------------------------------------------------------
   // Bus handshake: one wait cycle, write lands on the answer edge
   // ------------------------------------------------------------
   assign request  = READ || WRITE;
   assign wr_now   = WRITE && state.ack;
   assign low_lane = BYTEENABLE[0];
   assign protected_hit = ADDRESS == rtc_ctrl_pkg::OFS_ALARM_MONTH ||
                          ADDRESS == rtc_ctrl_pkg::OFS_ALARM_YEAR ||
                          ADDRESS == rtc_ctrl_pkg::OFS_CONTROL;

   always_comb begin
      next_state           = state;
      next_state.ack       = request && !state.ack;
      next_state.round_now = 1'b0;
      next_state.comp_now  = 1'b0;

      // Read data is readable whether locked or not
      if (READ && !state.ack) begin                                // [R18]
         unique case (ADDRESS)
            rtc_ctrl_pkg::OFS_ALARM_MONTH:
               next_state.rdata = {27'h000_0000, state.month};     // [R17]
            rtc_ctrl_pkg::OFS_ALARM_YEAR:
               next_state.rdata = {24'h00_0000, state.year};
            rtc_ctrl_pkg::OFS_CONTROL:
               next_state.rdata = {24'h00_0000,
                                   state.ctrl &
                                   rtc_ctrl_pkg::CTL_READ_MASK};   // [R5]
            rtc_ctrl_pkg::OFS_IRQ_STATUS:
               next_state.rdata = {28'h000_0000, state.status};
            rtc_ctrl_pkg::OFS_IRQ_MASK:
               next_state.rdata = {28'h000_0000, state.mask};
            rtc_ctrl_pkg::OFS_STATE:
               next_state.rdata = {30'h0000_0000, COUNTER_RUN, unlocked};
            default:
               next_state.rdata = 32'h0000_0000;
         endcase
      end

      if (wr_now && low_lane) begin
         if (protected_hit && !unlocked) begin
            next_state.status[rtc_ctrl_pkg::IRQ_REFUSED] = 1'b1;   // [R1]
         end else begin
            unique case (ADDRESS)
               rtc_ctrl_pkg::OFS_ALARM_MONTH:
                  next_state.month = WRITEDATA[4:0];               // [R2]
               rtc_ctrl_pkg::OFS_ALARM_YEAR:
                  next_state.year  = WRITEDATA[7:0];               // [R3]
               rtc_ctrl_pkg::OFS_CONTROL:
                  next_state.ctrl  = WRITEDATA[7:0] &
                                     rtc_ctrl_pkg::CTL_WRITE_MASK; // [R17]
               rtc_ctrl_pkg::OFS_IRQ_STATUS:
                  next_state.status = state.status & ~WRITEDATA[3:0];
               rtc_ctrl_pkg::OFS_IRQ_MASK:
                  next_state.mask = WRITEDATA[3:0] &
                                    rtc_ctrl_pkg::IRQ_MASK_BITS;
               default: ;
            endcase
         end
      end

      // Rounding is one-shot: the next time read consumes the bit
      if (TIME_READ && state.ctrl[rtc_ctrl_pkg::CTL_ROUND]) begin
         next_state.round_now = 1'b1;                              // [R13]
         if (!(wr_now && low_lane &&
               ADDRESS == rtc_ctrl_pkg::OFS_CONTROL)) begin
            next_state.ctrl[rtc_ctrl_pkg::CTL_ROUND] = 1'b0;
         end
      end

      next_state.comp_now = HOUR_TICK && COUNTER_RUN &&
                            state.ctrl[rtc_ctrl_pkg::CTL_HOUR_COMP]; // [R12]

      // Event set is applied after the register writes so it beats a same-cycle clear
      if (alarm_event) begin
         next_state.status[rtc_ctrl_pkg::IRQ_ALARM] = 1'b1;        // [R16]
      end
      if (wr_now && low_lane && protected_hit && !unlocked) begin
         next_state.status[rtc_ctrl_pkg::IRQ_REFUSED] = 1'b1;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state        <= '0;
         state.month  <= rtc_ctrl_pkg::MONTH_RESET;
         state.year   <= rtc_ctrl_pkg::YEAR_RESET;
         state.ctrl   <= rtc_ctrl_pkg::CTL_RESET;
         state.status <= rtc_ctrl_pkg::IRQ_RESET;
         state.mask   <= rtc_ctrl_pkg::IRQ_RESET;
      end else begin
         state <= next_state;
      end
   end

   // ------------------------------------------------------------
   // Outputs to the counter chain
   // ------------------------------------------------------------
   // Disable overrides run: a gated reference cannot count anyway
   assign REF_CLOCK_ENABLE   = !state.ctrl[rtc_ctrl_pkg::CTL_DISABLE]; // [R7]
   assign COUNTER_PRELOAD    = state.ctrl[rtc_ctrl_pkg::CTL_PRELOAD] &&
                               REF_CLOCK_ENABLE;                      // [R9]
   assign COUNTER_RUN        = state.ctrl[rtc_ctrl_pkg::CTL_RUN] &&   // [R14]
                               REF_CLOCK_ENABLE && !COUNTER_PRELOAD;
   assign ISOLATION_ENABLE   = state.ctrl[rtc_ctrl_pkg::CTL_ISOLATION]; // [R5]
   assign TWELVE_HOUR_SELECT = state.ctrl[rtc_ctrl_pkg::CTL_TWELVE];    // [R11]
   assign ROUND_NOW          = state.round_now;
   assign COMPENSATE_NOW     = state.comp_now;
   assign IRQ                = |(state.status & state.mask);          // [R16]
   assign READDATA           = state.rdata;
   assign WAITREQUEST        = request && !state.ack;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   locked_month_a: assert property (@(posedge CLOCK) disable iff (RST) // [R1]
      (!unlocked && WRITE) |=> $stable(state.month) && $stable(state.ctrl))
      else $error("protected register changed while locked");

   month_write_a: assert property (@(posedge CLOCK) disable iff (RST) // [R2]
      (unlocked && wr_now && low_lane &&
       ADDRESS == rtc_ctrl_pkg::OFS_ALARM_MONTH)
      |=> state.month == $past(WRITEDATA[4:0]))
      else $error("alarm month not stored");

   isolation_read_a: assert property (@(posedge CLOCK) disable iff (RST) // [R5]
      (READ && !WAITREQUEST && $past(ADDRESS == rtc_ctrl_pkg::OFS_CONTROL))
      |-> READDATA[7] == 1'b0 && READDATA[4] == 1'b0)
      else $error("write-only or reserved control bit read as one");

   disable_gate_a: assert property (@(posedge CLOCK) disable iff (RST) // [R7]
      state.ctrl[rtc_ctrl_pkg::CTL_DISABLE] |-> !REF_CLOCK_ENABLE &&
                                                !COUNTER_RUN)
      else $error("disabled module still clocked");

   preload_halt_a: assert property (@(posedge CLOCK) disable iff (RST) // [R9]
      COUNTER_PRELOAD |-> !COUNTER_RUN)
      else $error("counter runs during preload");

   round_once_a: assert property (@(posedge CLOCK) disable iff (RST) // [R13]
      ROUND_NOW |-> ##1 !ROUND_NOW)
      else $error("rounding repeated");

   round_cause_a: assert property (@(posedge CLOCK) disable iff (RST) // [R13]
      (TIME_READ && state.ctrl[rtc_ctrl_pkg::CTL_ROUND] && !WRITE)
      |=> ROUND_NOW && !state.ctrl[rtc_ctrl_pkg::CTL_ROUND])
      else $error("time read did not round once");

   comp_hour_a: assert property (@(posedge CLOCK) disable iff (RST) // [R12]
      COMPENSATE_NOW |-> $past(HOUR_TICK &&
                               state.ctrl[rtc_ctrl_pkg::CTL_HOUR_COMP]))
      else $error("compensation without hour tick");

   alarm_irq_a: assert property (@(posedge CLOCK) disable iff (RST) // [R16]
      (alarm_event && state.mask[rtc_ctrl_pkg::IRQ_ALARM] &&
       !($past(state.mask[rtc_ctrl_pkg::IRQ_ALARM]) == 1'b0))
      |=> IRQ)
      else $error("enabled alarm did not raise interrupt");

   answer_wait_a: assert property (@(posedge CLOCK) disable iff (RST)
      ($rose(request) || (request && $past(!WAITREQUEST))) |->
      WAITREQUEST ##1 (!WAITREQUEST || !request))
      else $error("bus answer not after one wait cycle");

endmodule // rtc_ctrl_regs

`default_nettype wire

// ---- design/write_lock.sv ----
`timescale 1ns/1ps
`default_nettype none

module write_lock (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        key_first_write,
   input  wire logic        key_second_write,
   input  wire logic [31:0] write_data,
   output logic             unlocked
);

   typedef enum logic [1:0] {LOCKED, HALF_OPEN, OPEN} lock_state_t;
   typedef struct packed {
      lock_state_t mode;
   } lock_t;

   lock_t state;
   lock_t next_state;

   // ------------------------------------------------------------
   // Two-key sequence; any wrong key closes the lock again
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      if (key_first_write) begin
         next_state.mode = (write_data == rtc_ctrl_pkg::KEY_FIRST) ?
                           HALF_OPEN : LOCKED;
      end else if (key_second_write) begin
         next_state.mode = (write_data == rtc_ctrl_pkg::KEY_SECOND &&
                            state.mode != LOCKED) ? OPEN : LOCKED;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         next_state_hold: state <= '{mode: LOCKED};
      end else begin
         state <= next_state;
      end
   end

   assign unlocked = (state.mode == OPEN);

   open_needs_key_a: assert property (@(posedge clock) disable iff (rst) // [R1]
      $rose(unlocked) |-> $past(key_second_write))
      else $error("lock opened without second key");

endmodule // write_lock

`default_nettype wire

// ---- pkg/rtc_ctrl_pkg.sv ----
`default_nettype none

package rtc_ctrl_pkg;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [5:0] OFS_ALARM_MONTH = 6'h00;
   localparam logic [5:0] OFS_ALARM_YEAR  = 6'h04;
   localparam logic [5:0] OFS_CONTROL     = 6'h08;
   localparam logic [5:0] OFS_KEY_FIRST   = 6'h0C;
   localparam logic [5:0] OFS_KEY_SECOND  = 6'h10;
   localparam logic [5:0] OFS_IRQ_STATUS  = 6'h14;
   localparam logic [5:0] OFS_IRQ_MASK    = 6'h18;
   localparam logic [5:0] OFS_STATE       = 6'h1C;

   // ------------------------------------------------------------
   // Field layouts
   // ------------------------------------------------------------
   localparam int MONTH_TENS_BIT  = 4;
   localparam int YEAR_TENS_LSB   = 4;
   localparam int CTL_RUN         = 0;
   localparam int CTL_ROUND       = 1;
   localparam int CTL_HOUR_COMP   = 2;
   localparam int CTL_TWELVE      = 3;
   localparam int CTL_PRELOAD     = 5;
   localparam int CTL_DISABLE     = 6;
   localparam int CTL_ISOLATION   = 7;
   localparam int IRQ_REFUSED     = 0;
   localparam int IRQ_ALARM       = 3;

   // Readable control bits: isolation reads zero, bit 4 reserved
   localparam logic [7:0] CTL_READ_MASK  = 8'h6F;
   localparam logic [7:0] CTL_WRITE_MASK = 8'hEF;
   localparam logic [3:0] IRQ_MASK_BITS  = 4'h9;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [4:0]  MONTH_RESET = 5'h01;
   localparam logic [7:0]  YEAR_RESET  = 8'h00;
   localparam logic [7:0]  CTL_RESET   = 8'h00;
   localparam logic [3:0]  IRQ_RESET   = 4'h0;

   // Unlock keys, values are arbitrary
   localparam logic [31:0] KEY_FIRST  = 32'h5A5A_1357;
   localparam logic [31:0] KEY_SECOND = 32'hA5A5_2468;

endpackage

`default_nettype wire

// ---- test/rtc_alarm_date_and_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module rtc_alarm_date_and_control_tb;

   logic        clock;
   logic        rst;
   logic [5:0]  address;
   logic        read;
   logic        write;
   logic [31:0] writedata;
   logic [3:0]  byteenable;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [4:0]  cur_month;
   logic [7:0]  cur_year;
   logic        time_match;
   logic        alarm_pm;
   logic        cur_pm;
   logic        time_read;
   logic        hour_tick;
   logic        run;
   logic        preload;
   logic        ref_en;
   logic        iso;
   logic        twelve;
   logic        round_now;
   logic        comp_now;
   logic        irq;
   int          fail_count;
   int          compares;
   int          cycles;
   int          hits;
   logic [31:0] rd;

   // Control writes, expected read-back and {iso,ref,preload,run,twelve}
   localparam logic [31:0] ctl_wr [6] = '{32'h0000_00FF, 32'h0000_0001,
      32'h0000_0021, 32'h0000_0080, 32'h0000_0049, 32'h0000_0000};
   localparam logic [31:0] ctl_rd [6] = '{32'h0000_006F, 32'h0000_0001,
      32'h0000_0021, 32'h0000_0000, 32'h0000_0049, 32'h0000_0000};
   localparam logic [4:0]  ctl_out [6] = '{5'h11, 5'h0A, 5'h0C, 5'h18,
      5'h01, 5'h08};

   rtc_ctrl_regs rtc_ctrl_regs_inst (
      .CLOCK              (clock),
      .RST                (rst),
      .ADDRESS            (address),
      .READ               (read),
      .WRITE              (write),
      .WRITEDATA          (writedata),
      .BYTEENABLE         (byteenable),
      .READDATA           (readdata),
      .WAITREQUEST        (waitrequest),
      .CURRENT_MONTH      (cur_month),
      .CURRENT_YEAR       (cur_year),
      .TIME_MATCH         (time_match),
      .ALARM_HOUR_PM      (alarm_pm),
      .CURRENT_HOUR_PM    (cur_pm),
      .TIME_READ          (time_read),
      .HOUR_TICK          (hour_tick),
      .COUNTER_RUN        (run),
      .COUNTER_PRELOAD    (preload),
      .REF_CLOCK_ENABLE   (ref_en),
      .ISOLATION_ENABLE   (iso),
      .TWELVE_HOUR_SELECT (twelve),
      .ROUND_NOW          (round_now),
      .COMPENSATE_NOW     (comp_now),
      .IRQ                (irq)
   );

   always #5 clock = ~clock;

   // ------------------------------------------------------------
   // Bus and checking tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Request held until the edge that sees waitrequest low
   task automatic bus(input logic wr, input logic [5:0] addr,
                      input logic [31:0] data, input logic [3:0] be);
      @(posedge clock);
      address    <= addr;
      writedata  <= data;
      byteenable <= be;
      write      <= wr;
      read       <= ~wr;
      do @(posedge clock); while (waitrequest !== 1'b0);
      rd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] addr, input logic [31:0] data);
      bus(1'b1, addr, data, 4'hF);
   endtask

   task automatic rchk(input string n, input logic [5:0] addr,
                       input logic [31:0] exp);
      bus(1'b0, addr, 32'h0000_0000, 4'hF);
      check(n, rd, exp);
   endtask

   // Match inputs change, then time for the event to settle
   task automatic drive(input logic [7:0] year, input logic pm,
                        input logic match);
      @(posedge clock);
      cur_year   <= year;
      cur_pm     <= pm;
      time_match <= match;
      repeat (4) @(posedge clock);
   endtask

   // One-cycle input pulse, then count output pulses over three cycles
   task automatic pulse_count(input logic is_tick);
      @(posedge clock);
      hour_tick <= is_tick;
      time_read <= ~is_tick;
      @(posedge clock);
      hour_tick <= 1'b0;
      time_read <= 1'b0;
      hits = 0;
      repeat (3) begin
         @(posedge clock);
         hits += is_tick ? int'(comp_now === 1'b1) : int'(round_now === 1'b1);
      end
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         finish_test();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      {address, read, write, writedata, byteenable} = '0;
      {cur_month, cur_year, time_match, cur_pm} = '0;
      {time_read, hour_tick} = '0;
      alarm_pm = 1'b1;
      fail_count = 0;
      compares = 0;
      cycles = 0;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      rchk("month reset", rtc_ctrl_pkg::OFS_ALARM_MONTH, 32'h0000_0001);
      rchk("ctrl reset", rtc_ctrl_pkg::OFS_CONTROL, 32'h0000_0000);
      wr(rtc_ctrl_pkg::OFS_ALARM_MONTH, 32'h0000_0005);
      wr(rtc_ctrl_pkg::OFS_ALARM_YEAR, 32'h0000_0055);
      wr(rtc_ctrl_pkg::OFS_CONTROL, 32'h0000_0001);
      @(posedge clock);
      check("run locked", {31'h0000_0000, run}, 32'h0000_0000);
      rchk("month locked", rtc_ctrl_pkg::OFS_ALARM_MONTH, 32'h0000_0001);
      rchk("year locked", rtc_ctrl_pkg::OFS_ALARM_YEAR, 32'h0000_0000);
      rchk("refused flag", rtc_ctrl_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
      wr(rtc_ctrl_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
      wr(rtc_ctrl_pkg::OFS_KEY_FIRST, rtc_ctrl_pkg::KEY_FIRST);
      wr(rtc_ctrl_pkg::OFS_KEY_SECOND, rtc_ctrl_pkg::KEY_SECOND);
      rchk("unlocked", rtc_ctrl_pkg::OFS_STATE, 32'h0000_0001);
      wr(rtc_ctrl_pkg::OFS_ALARM_MONTH, 32'hFFFF_FFF2);
      rchk("month bcd", rtc_ctrl_pkg::OFS_ALARM_MONTH, 32'h0000_0012);
      bus(1'b1, rtc_ctrl_pkg::OFS_ALARM_MONTH, 32'h0000_0009, 4'h0);
      rchk("month no lane", rtc_ctrl_pkg::OFS_ALARM_MONTH, 32'h0000_0012);
      wr(rtc_ctrl_pkg::OFS_ALARM_YEAR, 32'hFFFF_FF99);
      rchk("year bcd", rtc_ctrl_pkg::OFS_ALARM_YEAR, 32'h0000_0099);
      rchk("unmapped", 6'h20, 32'h0000_0000);
      for (int i = 0; i < 6; i++) begin
         wr(rtc_ctrl_pkg::OFS_CONTROL, ctl_wr[i]);
         @(posedge clock);
         check("ctrl pins", {27'h000_0000, iso, ref_en, preload, run, twelve},
               {27'h000_0000, ctl_out[i]});
         rchk("ctrl read", rtc_ctrl_pkg::OFS_CONTROL, ctl_rd[i]);
      end
      // Read-modify-write must put the isolation bit back by hand
      wr(rtc_ctrl_pkg::OFS_CONTROL, 32'h0000_0009);
      rchk("rmw read", rtc_ctrl_pkg::OFS_CONTROL, 32'h0000_0009);
      wr(rtc_ctrl_pkg::OFS_CONTROL, rd | 32'h0000_0080);
      @(posedge clock);
      check("rmw iso", {31'h0000_0000, iso}, 32'h0000_0001);
      pulse_count(1'b1);
      check("comp off", hits, 32'h0000_0000);
      wr(rtc_ctrl_pkg::OFS_CONTROL, 32'h0000_0005);
      pulse_count(1'b1);
      check("comp on", hits, 32'h0000_0001);
      pulse_count(1'b0);
      check("round off", hits, 32'h0000_0000);
      wr(rtc_ctrl_pkg::OFS_CONTROL, 32'h0000_0002);
      pulse_count(1'b0);
      check("round once", hits, 32'h0000_0001);
      rchk("round clear", rtc_ctrl_pkg::OFS_CONTROL, 32'h0000_0000);
      pulse_count(1'b0);
      check("round again", hits, 32'h0000_0000);
      // ------------------------------------------------------------
      // Alarm comparison and interrupt
      // ------------------------------------------------------------
      cur_month <= 5'h12;
      wr(rtc_ctrl_pkg::OFS_IRQ_MASK, 32'h0000_0008);
      wr(rtc_ctrl_pkg::OFS_CONTROL, 32'h0000_0008);
      drive(8'h98, 1'b1, 1'b1);
      check("year differs", {31'h0000_0000, irq}, 32'h0000_0000);
      drive(8'h99, 1'b0, 1'b0);
      drive(8'h99, 1'b0, 1'b1);
      check("pm differs", {31'h0000_0000, irq}, 32'h0000_0000);
      drive(8'h99, 1'b1, 1'b0);
      drive(8'h99, 1'b1, 1'b1);
      check("alarm irq", {31'h0000_0000, irq}, 32'h0000_0001);
      rchk("alarm status", rtc_ctrl_pkg::OFS_IRQ_STATUS, 32'h0000_0008);
      wr(rtc_ctrl_pkg::OFS_IRQ_STATUS, 32'h0000_0008);
      @(posedge clock);
      check("irq cleared", {31'h0000_0000, irq}, 32'h0000_0000);
      // In 24-hour mode the meridiem bits take no part
      wr(rtc_ctrl_pkg::OFS_IRQ_MASK, 32'h0000_0000);
      wr(rtc_ctrl_pkg::OFS_CONTROL, 32'h0000_0000);
      drive(8'h99, 1'b0, 1'b0);
      drive(8'h99, 1'b0, 1'b1);
      check("masked irq", {31'h0000_0000, irq}, 32'h0000_0000);
      rchk("24h status", rtc_ctrl_pkg::OFS_IRQ_STATUS, 32'h0000_0008);
      finish_test();
   end

endmodule // rtc_alarm_date_and_control_tb

`default_nettype wire
